// ---- dcls_pkg.sv ----
// Package for the DMA channel length, stride, chaining and diagnostics block.
// Assumes a single 20 MHz system clock and a 32-bit AXI4-Lite register port.
package dcls_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_SIZE     = 8'h00;
  localparam logic [7:0] OFS_STEP     = 8'h04;
  localparam logic [7:0] OFS_NEXT     = 8'h08;
  localparam logic [7:0] OFS_DIAG     = 8'h0c;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_SRC      = 8'h14;
  localparam logic [7:0] OFS_DST      = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
  // Field positions
  localparam int ROW_CNT_LSB   = 16;
  localparam int ROW_CNT_W     = 14;
  localparam int ROW_BYTES_W   = 16;
  localparam int DST_STEP_LSB  = 16;
  localparam int DESC_ALIGN_W  = 5;
  localparam int DIAG_LITE_BIT = 28;
  localparam int DIAG_VER_LSB  = 25;
  localparam int DIAG_ST_LSB   = 16;
  localparam int DIAG_TAG_LSB  = 8;
  localparam int DIAG_OWR_LSB  = 4;
  localparam int ERR_RD_BIT    = 2;
  localparam int ERR_FIFO_BIT  = 1;
  localparam int ERR_LAST_BIT  = 0;
  localparam int CTRL_START    = 0;
  localparam int CTRL_TWO_DIM  = 1;
  localparam int CTRL_CHAIN    = 2;
  // Constant and reset values (version is arbitrary, not a real part's)
  localparam logic       LITE_VALUE  = 1'b0;
  localparam logic [2:0] VERSION_ID  = 3'h5;
  localparam logic [7:0] BUS_TAG     = 8'h00;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam int          BEAT_BYTES = 4;
  localparam int          N_EVENTS   = 4;
  // Channel state machine
  typedef enum logic [8:0] {ST_IDLE, ST_READ, ST_WRITE, ST_ROW_END, ST_CHAIN, ST_DONE}
    dcls_state_type;
endpackage

// ---- dcls_sticky.sv ----
// Bank of sticky flags: set by hardware, cleared by write-one.
// Assumes set and clear pulses are on the system clock.
`timescale 1ns/1ps
module dcls_sticky #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  // Events and clears
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  // Flags
  output logic      [W-1:0] o_flag
);
  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag <= '0;
    end else begin
      o_flag <= (o_flag & ~i_clr) | i_set;
    end
  end
endmodule

// ---- dcls_channel.sv ----
// DMA channel: transfer length, 2D stride, descriptor chaining and diagnostics.
// Assumes an AXI4-Lite register master and an AXI memory side reduced to
// beat handshakes (read beat with last/error, write issue and response).
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Functional notes
// [R1] Linear mode: row count forms the top bits of one long byte count.
// [R2] 2D mode: row-count rows of row-byte count each, strides after every row.
// [R3] Length register counts down so reads show bytes still remaining.
// [R4] Row end in 2D adds signed upper stride half to destination address.
// [R5] Row end in 2D adds signed lower stride half to source address.
// [R6] Next-descriptor pointer is the address of the following descriptor.
// [R7] Pointer low five bits are not writable and read as zero.
// [R8] Software rewrites the pointer only while the channel is paused; the register takes writes in every state.
// [R9] Bit 28 of diagnostics reads zero: full-performance engine.
// [R10] Diagnostics hold a read-only 3-bit layout version field.
// [R11] Diagnostics expose the 9-bit state machine value.
// [R12] Diagnostics expose the 8-bit bus transaction tag.
// [R13] 4-bit outstanding-write count clears on new transfer and reset.
// [R14] Read error response sets sticky bit 2, write one clears.
// [R15] Read buffer error sets sticky bit 1, write one clears.
// [R16] Missing read last sets sticky bit 0, write one clears.
// [R17] Two-dimensional select bit picks 2D or linear length meaning.
// [R18] Step values are sign-extended before adding to addresses.
// [R19] Software writes reserved bits as zero and ignores them on read.
module dcls_channel (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Memory side: read beats
  output logic             o_mem_rd_req,
  output logic [31:0]      o_mem_rd_addr,
  input  wire logic        i_mem_rd_beat,
  input  wire logic        i_mem_rd_last,
  input  wire logic        i_mem_rd_err,
  input  wire logic        i_mem_fifo_err,
  // Memory side: writes
  output logic             o_mem_wr_req,
  output logic [31:0]      o_mem_wr_addr,
  input  wire logic        i_mem_wr_issue,
  input  wire logic        i_mem_wr_resp,
  // Descriptor chaining and status
  output logic             o_desc_fetch,
  output logic [31:0]      o_desc_addr,
  output logic [7:0]       o_bus_tag,
  output logic             o_busy,
  output logic             o_irq
);
  import dcls_pkg::*;

  // Registers
  logic [31:0]    transfer_size;
  logic [31:0]    row_step;
  logic [31:0]    next_descriptor_pointer;
  logic [31:0]    src_addr;
  logic [31:0]    dst_addr;
  logic [15:0]    row_bytes;
  logic           two_dim_select;
  logic           chain_en;
  logic [3:0]     out_writes;
  logic [N_EVENTS-1:0] irq_en;
  logic [N_EVENTS-1:0] irq_stat;
  logic [2:0]     err_flags;
  dcls_state_type state;
  dcls_state_type next_state;

  // Bus capture
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;

  // Decode a word offset; shared by the read and write paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a[7:2] == ofs[7:2]);
  endfunction

  // Apply byte enables to a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction

  // Write side: address and data may arrive in either order
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign wr_fire   = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= RST_WORD;
      w_strb  <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= 2'b00;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= (aw_addr > OFS_IRQ_EN) ? 2'b10 : 2'b00;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Software write strobes
  logic wr_size, wr_step, wr_next, wr_ctrl, wr_src, wr_dst, wr_diag, wr_iclr, wr_ien;
  logic start_req;
  assign wr_size = wr_fire && addr_hit(aw_addr, OFS_SIZE);
  assign wr_step = wr_fire && addr_hit(aw_addr, OFS_STEP);
  assign wr_next = wr_fire && addr_hit(aw_addr, OFS_NEXT);
  assign wr_diag = wr_fire && addr_hit(aw_addr, OFS_DIAG);
  assign wr_ctrl = wr_fire && addr_hit(aw_addr, OFS_CTRL);
  assign wr_src  = wr_fire && addr_hit(aw_addr, OFS_SRC);
  assign wr_dst  = wr_fire && addr_hit(aw_addr, OFS_DST);
  assign wr_iclr = wr_fire && addr_hit(aw_addr, OFS_IRQ_CLR);
  assign wr_ien  = wr_fire && addr_hit(aw_addr, OFS_IRQ_EN);
  assign start_req = wr_ctrl && w_strb[0] && w_data[CTRL_START] && (state == ST_IDLE);

  // Transfer geometry
  logic        row_last;
  logic        xfer_last;
  logic [15:0] row_cnt;
  logic [29:0] lin_len;
  logic [15:0] beat_bytes;
  assign row_cnt   = {2'b00, transfer_size[ROW_CNT_LSB +: ROW_CNT_W]};
  assign lin_len   = transfer_size[29:0];                                 // [R1]
  assign beat_bytes = (two_dim_select && row_bytes < 16'(BEAT_BYTES)) ? row_bytes
                    : 16'(BEAT_BYTES);
  assign row_last  = two_dim_select ? (transfer_size[15:0] <= beat_bytes)
                                    : (lin_len <= 30'(BEAT_BYTES));
  assign xfer_last = two_dim_select ? (row_cnt <= 16'd1) : 1'b1;         // [R2]

  // Channel state machine: one read beat then one write per word
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    if (start_req) next_state = ST_READ;
      ST_READ:    if (i_mem_rd_beat) next_state = ST_WRITE;
      ST_WRITE:   if (i_mem_wr_issue) next_state = row_last ? ST_ROW_END : ST_READ;
      ST_ROW_END: next_state = xfer_last ? ST_CHAIN : ST_READ;
      ST_CHAIN:   next_state = (chain_en && next_descriptor_pointer != RST_WORD) ? ST_IDLE
                                                                              : ST_DONE;
      ST_DONE:    next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) state <= ST_IDLE;
    else         state <= next_state;
  end

  // Length, addresses and stride stepping
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      transfer_size <= RST_WORD;
      src_addr      <= RST_WORD;
      dst_addr      <= RST_WORD;
      row_bytes     <= 16'h0000;
    end else begin
      if (wr_size && state == ST_IDLE) begin
        transfer_size <= merge(transfer_size, w_data, w_strb) & 32'h3fff_ffff; // [R19]
      end else if (start_req) begin
        row_bytes <= transfer_size[15:0];
      end else if (state == ST_WRITE && i_mem_wr_issue) begin
        dst_addr <= dst_addr + 32'(BEAT_BYTES);
        src_addr <= src_addr + 32'(BEAT_BYTES);
        if (two_dim_select) begin
          transfer_size[15:0] <= row_last ? 16'h0000 : transfer_size[15:0] - beat_bytes; // [R3]
        end else begin
          transfer_size <= row_last ? RST_WORD
                                    : {2'b00, lin_len - 30'(BEAT_BYTES)}; // [R3] [R1]
        end
      end else if (state == ST_ROW_END && two_dim_select) begin
        // Sign-extend so a negative step walks the address downward
        dst_addr <= dst_addr + {{16{row_step[31]}}, row_step[31:16]};     // [R4] [R18]
        src_addr <= src_addr + {{16{row_step[15]}}, row_step[15:0]};      // [R5] [R18]
        transfer_size[ROW_CNT_LSB +: ROW_CNT_W] <= ROW_CNT_W'(row_cnt - 16'd1); // [R2] [R3]
        transfer_size[15:0] <= xfer_last ? 16'h0000 : row_bytes;          // [R2]
      end
      if (wr_src && state == ST_IDLE) src_addr <= merge(src_addr, w_data, w_strb);
      if (wr_dst && state == ST_IDLE) dst_addr <= merge(dst_addr, w_data, w_strb);
    end
  end

  // Stride, pointer and control; pointer writes are safe only when idle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      row_step                <= RST_WORD;
      next_descriptor_pointer <= RST_WORD;
      two_dim_select          <= 1'b0;
      chain_en                <= 1'b0;
      irq_en                  <= '0;
    end else begin
      if (wr_step) row_step <= merge(row_step, w_data, w_strb);
      if (wr_next) begin
        next_descriptor_pointer <= merge(next_descriptor_pointer, w_data, w_strb)
                                   & ~32'h0000_001f;                      // [R7] [R8]
      end
      if (wr_ctrl && w_strb[0] && state == ST_IDLE) begin
        two_dim_select <= w_data[CTRL_TWO_DIM];                           // [R17]
        chain_en       <= w_data[CTRL_CHAIN];
      end
      if (wr_ien) irq_en <= w_data[N_EVENTS-1:0];
    end
  end

  // Outstanding writes: clear on start, count issues up and responses down
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_writes <= 4'h0;                                                 // [R13]
    end else if (start_req) begin
      out_writes <= 4'h0;                                                 // [R13]
    end else begin
      case ({i_mem_wr_issue && state == ST_WRITE, i_mem_wr_resp && out_writes != 4'h0})
        2'b10:   out_writes <= (out_writes == 4'hf) ? out_writes : out_writes + 4'h1;
        2'b01:   out_writes <= out_writes - 4'h1;
        default: out_writes <= out_writes;
      endcase
    end
  end

  // Error flags and interrupt events
  logic [2:0]          err_set;
  logic [2:0]          err_clr;
  logic [N_EVENTS-1:0] ev_set;
  logic [N_EVENTS-1:0] ev_clr;
  logic                rd_beat;
  assign rd_beat = state == ST_READ && i_mem_rd_beat;
  assign err_set[ERR_RD_BIT]   = rd_beat && i_mem_rd_err;                 // [R14]
  assign err_set[ERR_FIFO_BIT] = i_mem_fifo_err;                          // [R15]
  // Every read is one beat, so last must accompany every beat
  assign err_set[ERR_LAST_BIT] = rd_beat && !i_mem_rd_last;               // [R16]
  assign err_clr = wr_diag ? w_data[2:0] & {3{w_strb[0]}} : 3'b000;       // [R14] [R15] [R16]
  assign ev_set  = {state == ST_DONE, err_set};
  assign ev_clr  = wr_iclr ? w_data[N_EVENTS-1:0] : '0;

  dcls_sticky #(.W(3)) u_err (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_set     (err_set),
    .i_clr     (err_clr),
    .o_flag    (err_flags)
  );

  dcls_sticky #(.W(N_EVENTS)) u_irq (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_set     (ev_set),
    .i_clr     (ev_clr),
    .o_flag    (irq_stat)
  );

  assign o_irq = |(irq_stat & irq_en);

  // Read path: one read at a time, data registered
  logic [31:0] diag_word;
  logic [31:0] rd_word;
  assign diag_word = {3'b000, LITE_VALUE, VERSION_ID, 9'(state), BUS_TAG,  // [R9] [R10] [R11] [R12]
                      out_writes, 1'b0, err_flags};                        // [R13]
  always_comb begin
    rd_word = RST_WORD;
    if      (addr_hit(i_araddr, OFS_SIZE))     rd_word = transfer_size;  // [R3]
    else if (addr_hit(i_araddr, OFS_STEP))     rd_word = row_step;
    else if (addr_hit(i_araddr, OFS_NEXT))     rd_word = next_descriptor_pointer;
    else if (addr_hit(i_araddr, OFS_DIAG))     rd_word = diag_word;
    else if (addr_hit(i_araddr, OFS_CTRL))     rd_word = {29'h0, chain_en, two_dim_select,
                                                          state != ST_IDLE};
    else if (addr_hit(i_araddr, OFS_SRC))      rd_word = src_addr;
    else if (addr_hit(i_araddr, OFS_DST))      rd_word = dst_addr;
    else if (addr_hit(i_araddr, OFS_IRQ_STAT)) rd_word = {28'h0, irq_stat};
    else if (addr_hit(i_araddr, OFS_IRQ_EN))   rd_word = {28'h0, irq_en};
  end

  assign o_arready = !o_rvalid;
  assign rd_fire   = i_arvalid && o_arready;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= RST_WORD;
      o_rresp  <= 2'b00;
    end else if (rd_fire) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_word;
      o_rresp  <= (i_araddr > OFS_IRQ_EN) ? 2'b10 : 2'b00;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Memory side outputs
  assign o_mem_rd_req  = state == ST_READ;
  assign o_mem_rd_addr = src_addr;
  assign o_mem_wr_req  = state == ST_WRITE;
  assign o_mem_wr_addr = dst_addr;
  assign o_desc_fetch  = state == ST_CHAIN && chain_en && next_descriptor_pointer != RST_WORD;
  assign o_desc_addr   = next_descriptor_pointer;                         // [R6]
  assign o_bus_tag     = BUS_TAG;                                         // [R12]
  assign o_busy        = state != ST_IDLE;
endmodule

// ---- dcls_asserts.sv ----
// Checker for the DMA channel block: timing relations seen at its ports.
// Assumes it is bound into dcls_channel and sees only that module's ports.
`timescale 1ns/1ps
module dcls_asserts
  import dcls_pkg::*;
(
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  // Register read side
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [31:0] o_rdata,
  // Memory side
  input wire logic        o_mem_rd_req,
  input wire logic [31:0] o_mem_rd_addr,
  input wire logic        i_mem_rd_beat,
  input wire logic        o_mem_wr_req,
  input wire logic [31:0] o_mem_wr_addr,
  input wire logic        i_mem_wr_issue,
  // Chaining and status
  input wire logic        o_desc_fetch,
  input wire logic [31:0] o_desc_addr,
  input wire logic [7:0]  o_bus_tag,
  input wire logic        o_busy
);
  // One clock domain, so clocking and disable are stated once
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  ptr_align_a: assert property (o_desc_fetch |-> o_desc_addr[4:0] == 5'h00)
    else $error("descriptor address not aligned");
  fetch_pulse_a: assert property (o_desc_fetch |=> !o_desc_fetch)
    else $error("descriptor fetch longer than one cycle");
  fetch_busy_a: assert property (o_desc_fetch |-> o_busy)
    else $error("descriptor fetch while idle");
  bus_tag_a: assert property (o_bus_tag == BUS_TAG)
    else $error("bus tag changed");
  rd_hold_a: assert property (o_mem_rd_req && !i_mem_rd_beat |=>
    o_mem_rd_req && $stable(o_mem_rd_addr)) else $error("read request dropped or moved");
  wr_hold_a: assert property (o_mem_wr_req && !i_mem_wr_issue |=>
    o_mem_wr_req && $stable(o_mem_wr_addr)) else $error("write request dropped or moved");
  one_side_a: assert property (!(o_mem_rd_req && o_mem_wr_req))
    else $error("read and write requested together");
  beat_write_a: assert property (o_mem_rd_req && i_mem_rd_beat |=> o_mem_wr_req)
    else $error("read beat not followed by a write");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  req_busy_a: assert property (o_mem_rd_req || o_mem_wr_req |-> o_busy)
    else $error("memory request while idle");
  // Main scenarios reached
  cover property (o_desc_fetch);
  cover property (o_mem_rd_req && i_mem_rd_beat);
  cover property (o_mem_wr_req && i_mem_wr_issue);
endmodule

bind dcls_channel dcls_asserts u_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
  .o_mem_rd_req(o_mem_rd_req), .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_beat(i_mem_rd_beat),
  .o_mem_wr_req(o_mem_wr_req), .o_mem_wr_addr(o_mem_wr_addr), .i_mem_wr_issue(i_mem_wr_issue),
  .o_desc_fetch(o_desc_fetch), .o_desc_addr(o_desc_addr), .o_bus_tag(o_bus_tag),
  .o_busy(o_busy));

// ---- dcls_mem_model.sv ----
// Memory-side model: read beats after a set wait, write issue and responses.
// Assumes the channel holds its requests until accepted.
`timescale 1ns/1ps
module dcls_mem_model (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // Requests and test controls
  input  wire logic        i_rd_req,
  input  wire logic        i_wr_req,
  input  wire logic        i_hold,
  input  wire logic        i_drop_last,
  input  wire logic        i_err,
  input  wire logic [3:0]  i_delay,
  input  wire logic [15:0] i_row_words,
  // Answers
  output logic             o_beat,
  output logic             o_last,
  output logic             o_err,
  output logic             o_issue,
  output logic             o_resp
);
  logic [3:0]  wait_cnt;
  logic [15:0] word_cnt;
  logic [3:0]  owed;
  logic        row_end;
  assign row_end = (word_cnt == i_row_words - 16'h1);
  // Read beats; every read is a single beat, so last comes with each one.
  // A dropped last is injected only on a row's final word when asked.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_cnt <= 4'h0;
      word_cnt <= 16'h0;
      o_beat   <= 1'b0;
      o_last   <= 1'b0;
      o_err    <= 1'b0;
    end else if (i_rd_req && !o_beat && !i_hold && wait_cnt >= i_delay) begin
      o_beat   <= 1'b1;
      o_last   <= !(row_end && i_drop_last);
      o_err    <= i_err;
      wait_cnt <= 4'h0;
      word_cnt <= row_end ? 16'h0 : word_cnt + 16'h1;
    end else begin
      o_beat   <= 1'b0;
      o_last   <= ~o_last; // Flags are meaningless between beats, so never stale
      o_err    <= ~o_err;
      wait_cnt <= i_rd_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
  // Writes accepted at once; responses trail, at most one every other cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_issue <= 1'b0;
      o_resp  <= 1'b0;
      owed    <= 4'h0;
    end else begin
      o_issue <= i_wr_req && !o_issue && !i_hold;
      o_resp  <= !i_hold && !o_resp && owed != 4'h0;
      owed    <= owed + {3'h0, o_issue} - {3'h0, o_resp};
    end
  end
endmodule

// ---- tb_dma_channel_length_stride_status.sv ----
// Self-checking bench for the DMA channel length, stride and diagnostics block.
// Assumes dcls_channel, dcls_mem_model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_dma_channel_length_stride_status;
  import dcls_pkg::*;
  logic        i_sys_clk, i_nrst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic        i_arvalid, o_arready, o_rvalid, i_rready, o_mem_rd_req, i_mem_rd_beat;
  logic        i_mem_rd_last, i_mem_rd_err, i_mem_fifo_err, o_mem_wr_req, i_mem_wr_issue;
  logic        i_mem_wr_resp, o_desc_fetch, o_busy, o_irq, hold, drop, err;
  logic [7:0]  i_awaddr, i_araddr, o_bus_tag;
  logic [3:0]  i_wstrb, dly;
  logic [1:0]  o_bresp, o_rresp, rsp;
  logic [15:0] row_words;
  logic [31:0] i_wdata, o_rdata, o_mem_rd_addr, o_mem_wr_addr, o_desc_addr, rdv, fetch_a;
  logic [31:0] rd_q[$], wr_q[$];
  int          n_errors, check_count, n_iss, n_rsp, n_bt, n;
  dcls_channel DUT (.*);
  dcls_mem_model u_mem (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rd_req(o_mem_rd_req),
    .i_wr_req(o_mem_wr_req), .i_hold(hold), .i_drop_last(drop), .i_err(err), .i_delay(dly),
    .i_row_words(row_words), .o_beat(i_mem_rd_beat), .o_last(i_mem_rd_last),
    .o_err(i_mem_rd_err), .o_issue(i_mem_wr_issue), .o_resp(i_mem_wr_resp));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Record memory traffic as it is accepted
  always @(posedge i_sys_clk) begin
    if (i_mem_rd_beat && o_mem_rd_req) rd_q.push_back(o_mem_rd_addr);
    if (i_mem_wr_issue && o_mem_wr_req) wr_q.push_back(o_mem_wr_addr);
    if (o_desc_fetch) fetch_a = o_desc_addr;
    n_bt += int'(i_mem_rd_beat);
    n_iss += int'(i_mem_wr_issue);
    n_rsp += int'(i_mem_wr_resp);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo;
    n_errors++;
    results();
  endtask
  // Write address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    rsp = o_bresp;
    i_bready <= 1'b0;
    if (n == 40) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    rdv = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    if (n == 40) tmo();
  endtask
  task automatic rst;
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
  endtask
  // Busy may linger for a whole transfer; bounded so a hang still ends the run
  task automatic idle;
    for (n = 0; n < 500; n++) begin
      @(posedge i_sys_clk);
      if (!o_busy) break;
    end
    if (n == 500) tmo();
  endtask
  task automatic t_reset;
    rd(OFS_SIZE);
    chk("size", rdv, RST_WORD);
    rd(OFS_DIAG);
    chk("diag", rdv, {3'h0, LITE_VALUE, VERSION_ID, 9'h0, BUS_TAG, 8'h00});
    rd(8'h40);
    chk("unmapped resp", {30'h0, rsp}, 32'h2);
    wr(OFS_NEXT, 32'hffff_ffff); // Channel idle here
    chk("write resp", {30'h0, rsp}, 32'h0);
    rd(OFS_NEXT);
    chk("pointer", rdv, 32'hffff_ffe0);
  endtask
  // Long linear run frozen mid-way, inspected, then cut off by reset
  task automatic t_linear;
    dly <= 4'h1;
    row_words <= 16'hffff;
    wr(OFS_SIZE, 32'h0001_0008); // Reserved top bits written as zero
    wr(OFS_CTRL, 32'h1);
    for (n = 0; n < 300 && n_iss < 5; n++) @(posedge i_sys_clk);
    hold <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    rd(OFS_SIZE);
    chk("remaining", rdv, 32'h0001_0008 - 32'(4 * n_iss));
    rd(OFS_DIAG);
    chk("diag run", rdv, {3'h0, LITE_VALUE, VERSION_ID, (n_bt > n_iss) ? 9'(ST_WRITE) :
      9'(ST_READ), BUS_TAG, 4'(n_iss - n_rsp), 4'h0});
    rst();
    hold <= 1'b0;
    rd(OFS_DIAG);
    chk("pending after reset", rdv & 32'hf0, 32'h0);
  endtask
  task automatic t_two_dim;
    rd_q.delete();
    wr_q.delete();
    dly <= 4'h3;
    row_words <= 16'h2;
    wr(OFS_SRC, 32'h100);
    wr(OFS_DST, 32'h200);
    wr(OFS_STEP, 32'hfff8_0010);
    wr(OFS_NEXT, 32'h1000);
    wr(OFS_SIZE, 32'h0002_0008);
    wr(OFS_CTRL, 32'h7);
    idle();
    chk("beats", 32'(rd_q.size()), 32'h4);
    chk("src row", rd_q[2], 32'h118);
    chk("dst row", wr_q[2], 32'h200);
    chk("fetch", fetch_a, 32'h1000);
  endtask
  // All three error flags at once, then read error cleared alone and the other two together
  task automatic t_errors;
    dly <= 4'h0;
    row_words <= 16'h1;
    drop <= 1'b1;
    err <= 1'b1;
    wr(OFS_IRQ_EN, 32'h8);
    wr(OFS_SIZE, 32'h4);
    wr(OFS_CTRL, 32'h1);
    i_mem_fifo_err <= 1'b1;
    @(posedge i_sys_clk);
    i_mem_fifo_err <= 1'b0;
    idle();
    drop <= 1'b0;
    err <= 1'b0;
    rd(OFS_DIAG);
    chk("errors", rdv & 32'h7, 32'h7);
    chk("irq", {31'h0, o_irq}, 32'h1);
    rd(OFS_IRQ_STAT);
    chk("irq status", rdv, 32'hf);
    wr(OFS_IRQ_CLR, 32'h8);
    chk("irq masked", {31'h0, o_irq}, 32'h0);
    wr(OFS_DIAG, 32'h4);
    rd(OFS_DIAG);
    chk("read err clear", rdv & 32'h7, 32'h3);
    wr(OFS_DIAG, 32'h3);
    rd(OFS_DIAG);
    chk("other clears", rdv & 32'h7, 32'h0);
  endtask
  initial begin
    {i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_mem_fifo_err} = 7'h00;
    {hold, drop, err, dly, row_words} = 23'h0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = {16'h0, 32'h0, 4'hf};
    rst();
    t_reset();
    t_linear();
    t_two_dim();
    t_errors();
    results();
  end
endmodule
